// ---- design/ltc_pkg.sv ----
// Constants for the two-counter timebase and capture timer.
// Assumes pclk is the oscillator clock and the bus is APB with 32-bit data.
package ltc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_TB2_CTRL_STATUS = 6'h08;
	localparam logic [5:0] IDX_RELOAD = 6'h09;
	localparam logic [5:0] IDX_COUNT2 = 6'h0a;
	localparam logic [5:0] IDX_TB1_CAP_CTRL_STATUS = 6'h0b;
	localparam logic [5:0] IDX_CAPTURE = 6'h0c;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h0d;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h0e;

	// Field positions, second control/status register
	localparam int TB2_FLAG_BIT = 0;
	localparam int TB2_IE_BIT = 1;
	// Field positions, first control/status register
	localparam int TB1_FLAG_BIT = 3;
	localparam int TB1_IE_BIT = 4;
	localparam int TB_SEL_BIT = 5;
	localparam int CAP_FLAG_BIT = 6;
	localparam int CAP_IE_BIT = 7;
	// Sticky interrupt status and mask layout
	localparam int IRQ_TB1_BIT = 0;
	localparam int IRQ_TB2_BIT = 1;
	localparam int IRQ_CAP_BIT = 2;
	localparam int IRQ_W = 3;

	// Timing, in oscillator periods
	localparam int PRESCALE = 32;
	localparam int TB_SHORT_OSC = 8000;
	localparam int TB_LONG_OSC = 16000;
	localparam logic [4:0] PRESC_LAST = 5'(PRESCALE - 1);
	localparam logic [7:0] CNT1_LAST = 8'(TB_SHORT_OSC / PRESCALE - 1);
	localparam logic [7:0] CNT2_LAST = 8'hff;

	// Reset values
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] CAPTURE_RST = 8'h00;
	localparam logic CAP_FLAG_RST = 1'b0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

	typedef struct packed {
		logic [4:0] presc;
		logic [7:0] cnt1;
		logic tb_half;
		logic [7:0] cnt2;
		logic [7:0] reload;
		logic tb2_ie;
		logic tb2_flag;
		logic cap_ie;
		logic cap_flag;
		logic tb_sel;
		logic tb1_ie;
		logic tb1_flag;
		logic [7:0] capture;
		logic pin_prev;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
		logic irq;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ltc_state_s;

endpackage

// ---- design/ltc_timer.sv ----
// Two 8-bit timebase counters and an 8-bit input capture behind an APB slave.
// Assumes pclk is the oscillator, capture pin and halt input are synchronous.
//
// Operation
// - Timebase-2 enable gates counter-2 overflow requests
// - Counter-2 overflow sets flag; status read clears
// - Second status bits 7:2 read zero
// - Reload register read/write, copied on overflow
// - Counter-2 register read-only, resets zero
// - Capture enable gates capture requests
// - Capture sets flag; capture register read clears
// - Capture flag undefined; software reads once (here the flag resets to zero)
// - Period select: 8000 or 16000 oscillator periods
// - Timebase-1 enable gates timebase-1 requests
// - Counter-1 wrap sets flag, every second one in long period; status read clears
// - Pin edge with flag clear captures count
// - Capture register read-only, resets zero
// - Five registers at indices 08 to 0C; interrupt status and mask added at 0D and 0E
// - Hidden counter 1 wraps F9h to 00h
// - Counter 2 passes FFh, restarts from reload
// - Capture from counter 1, inhibited while flagged
// - Both counters stop in deepest halt
`timescale 1ns/1ps
`default_nettype none

module ltc_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic capture_input_pin,
	input wire logic halt_stop,
	output logic irq
);

	ltc_pkg::ltc_state_s s_q;
	ltc_pkg::ltc_state_s s_d;

	function automatic logic mapped(input logic [5:0] idx);
		mapped = (idx >= ltc_pkg::IDX_TB2_CTRL_STATUS) && (idx <= ltc_pkg::IDX_IRQ_MASK);
	endfunction

	function automatic logic [7:0] reg_value(input logic [5:0] idx, input ltc_pkg::ltc_state_s s);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			ltc_pkg::IDX_TB2_CTRL_STATUS: begin
				v[ltc_pkg::TB2_IE_BIT] = s.tb2_ie;
				v[ltc_pkg::TB2_FLAG_BIT] = s.tb2_flag;
			end
			ltc_pkg::IDX_RELOAD: v = s.reload;
			ltc_pkg::IDX_COUNT2: v = s.cnt2;
			ltc_pkg::IDX_TB1_CAP_CTRL_STATUS: begin
				v[ltc_pkg::CAP_IE_BIT] = s.cap_ie;
				v[ltc_pkg::CAP_FLAG_BIT] = s.cap_flag;
				v[ltc_pkg::TB_SEL_BIT] = s.tb_sel;
				v[ltc_pkg::TB1_IE_BIT] = s.tb1_ie;
				v[ltc_pkg::TB1_FLAG_BIT] = s.tb1_flag;
			end
			ltc_pkg::IDX_CAPTURE: v = s.capture;
			ltc_pkg::IDX_IRQ_STATUS: v = {5'h00, s.irq_st};
			ltc_pkg::IDX_IRQ_MASK: v = {5'h00, s.irq_mask};
			default: v = 8'h00;
		endcase
		reg_value = v;
	endfunction

	logic [5:0] idx;
	logic setup;
	logic done;
	logic wr_done;
	logic rd_done;
	logic tick;
	logic wrap1;
	logic ovf2;
	logic tb1_event;
	logic cap_event;
	localparam int IRQ_W_L = ltc_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] raw_ev;

	assign idx = paddr[7:2];
	assign setup = psel && !penable;
	assign done = psel && penable && s_q.pready;
	assign wr_done = done && pwrite && pstrb[0];
	assign rd_done = done && !pwrite;
	// Counters freeze while halted; prescaler too so the phase is kept
	assign tick = !halt_stop && (s_q.presc == ltc_pkg::PRESC_LAST);
	assign wrap1 = tick && (s_q.cnt1 == ltc_pkg::CNT1_LAST);
	assign ovf2 = tick && (s_q.cnt2 == ltc_pkg::CNT2_LAST);
	// Long period only flags on the second wrap
	assign tb1_event = wrap1 && (!s_q.tb_sel || s_q.tb_half);
	assign cap_event = (capture_input_pin != s_q.pin_prev) && !s_q.cap_flag;
	assign raw_ev[ltc_pkg::IRQ_TB1_BIT] = tb1_event && s_q.tb1_ie;
	assign raw_ev[ltc_pkg::IRQ_TB2_BIT] = ovf2 && s_q.tb2_ie;
	assign raw_ev[ltc_pkg::IRQ_CAP_BIT] = cap_event && s_q.cap_ie;

	always_comb begin
		s_d = s_q;
		s_d.pin_prev = capture_input_pin;

		if (!halt_stop) begin
			s_d.presc = s_q.presc + 5'h01;
		end
		if (tick) begin
			s_d.cnt1 = wrap1 ? 8'h00 : s_q.cnt1 + 8'h01;
			s_d.cnt2 = ovf2 ? s_q.reload : s_q.cnt2 + 8'h01;
		end
		if (wrap1) begin
			s_d.tb_half = s_q.tb_sel ? !s_q.tb_half : 1'b0;
		end

		// Status read-to-clear drops only the timebase flags the read actually returned set,
		// so an event arriving during the access is kept; a capture register read clears cap_flag regardless
		if (rd_done && idx == ltc_pkg::IDX_TB2_CTRL_STATUS && s_q.prdata[ltc_pkg::TB2_FLAG_BIT]) begin
			s_d.tb2_flag = 1'b0;
		end
		if (rd_done && idx == ltc_pkg::IDX_TB1_CAP_CTRL_STATUS && s_q.prdata[ltc_pkg::TB1_FLAG_BIT]) begin
			s_d.tb1_flag = 1'b0;
		end
		if (rd_done && idx == ltc_pkg::IDX_CAPTURE) begin
			s_d.cap_flag = 1'b0;
		end

		if (wr_done) begin
			unique case (idx)
				ltc_pkg::IDX_TB2_CTRL_STATUS: s_d.tb2_ie = pwdata[ltc_pkg::TB2_IE_BIT];
				ltc_pkg::IDX_RELOAD: s_d.reload = pwdata[7:0];
				ltc_pkg::IDX_TB1_CAP_CTRL_STATUS: begin
					s_d.cap_ie = pwdata[ltc_pkg::CAP_IE_BIT];
					s_d.tb_sel = pwdata[ltc_pkg::TB_SEL_BIT];
					s_d.tb1_ie = pwdata[ltc_pkg::TB1_IE_BIT];
				end
				ltc_pkg::IDX_IRQ_STATUS: s_d.irq_st = s_q.irq_st & ~pwdata[IRQ_W_L-1:0];
				ltc_pkg::IDX_IRQ_MASK: s_d.irq_mask = pwdata[IRQ_W_L-1:0];
				default: s_d.irq_mask = s_d.irq_mask;
			endcase
		end

		// Hardware sets win over any clear in the same cycle
		if (ovf2) begin
			s_d.tb2_flag = 1'b1;
		end
		if (tb1_event) begin
			s_d.tb1_flag = 1'b1;
		end
		if (cap_event) begin
			s_d.capture = s_q.cnt1;
			s_d.cap_flag = 1'b1;
		end
		s_d.irq_st = s_d.irq_st | raw_ev;
		s_d.irq = |(s_d.irq_st & s_d.irq_mask);

		// No wait state: data is sampled in setup and shown in access
		s_d.pready = setup;
		s_d.pslverr = setup && !mapped(idx);
		s_d.prdata = s_q.prdata;
		if (setup) begin
			s_d.prdata = {24'h000000, (pwrite ? 8'h00 : reg_value(idx, s_q))};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.reload <= ltc_pkg::RELOAD_RST;
			s_q.cnt2 <= ltc_pkg::RELOAD_RST;
			s_q.capture <= ltc_pkg::CAPTURE_RST;
			s_q.cap_flag <= ltc_pkg::CAP_FLAG_RST;
			s_q.irq_mask <= ltc_pkg::IRQ_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign irq = s_q.irq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_cnt1_wrap: assert property (wrap1 |=> s_q.cnt1 == 8'h00)
		else $error("counter 1 did not wrap to zero");
	a_cnt2_reload: assert property (ovf2 |=> s_q.cnt2 == $past(s_q.reload) && s_q.tb2_flag)
		else $error("counter 2 did not reload");
	a_tb2_flag_set: assert property (ovf2 |=> s_q.tb2_flag)
		else $error("timebase 2 flag not set on overflow");
	a_ctrl2_reserved: assert property (setup && !pwrite && idx == ltc_pkg::IDX_TB2_CTRL_STATUS
		|=> s_q.prdata[7:2] == 6'h00 && s_q.pready)
		else $error("reserved bits read nonzero");
	a_cap_take: assert property (cap_event |=> s_q.capture == $past(s_q.cnt1) && s_q.cap_flag)
		else $error("capture value or flag wrong");
	a_cap_inhibit: assert property (s_q.cap_flag && !rd_done |=> $stable(s_q.capture) && s_q.cap_flag)
		else $error("capture happened while flagged");
	a_halt_freeze: assert property (halt_stop |=> $stable(s_q.cnt1) && $stable(s_q.cnt2))
		else $error("counter moved during halt");
	a_tb1_gate: assert property (!s_q.tb1_ie |=> !$rose(s_q.irq_st[ltc_pkg::IRQ_TB1_BIT]))
		else $error("timebase 1 request while disabled");
	a_tb2_gate: assert property (!s_q.tb2_ie |=> !$rose(s_q.irq_st[ltc_pkg::IRQ_TB2_BIT]))
		else $error("timebase 2 request while disabled");
	a_cap_gate: assert property (!s_q.cap_ie |=> !$rose(s_q.irq_st[ltc_pkg::IRQ_CAP_BIT]))
		else $error("capture request while disabled");
	a_long_period: assert property (wrap1 && s_q.tb_sel && !s_q.tb_half |=> !$rose(s_q.tb1_flag))
		else $error("long period flagged on first wrap");
	a_tb1_read_clr: assert property (rd_done && idx == ltc_pkg::IDX_TB1_CAP_CTRL_STATUS
		&& s_q.prdata[ltc_pkg::TB1_FLAG_BIT] && !tb1_event |=> !s_q.tb1_flag)
		else $error("timebase 1 flag not cleared by read");
	a_cap_read_clr: assert property (rd_done && idx == ltc_pkg::IDX_CAPTURE && !cap_event
		|=> !s_q.cap_flag)
		else $error("capture flag not cleared by read");
	a_cnt2_ro: assert property (wr_done && idx == ltc_pkg::IDX_COUNT2 && !tick
		|=> $stable(s_q.cnt2))
		else $error("counter 2 changed by write");
	a_unmapped_err: assert property (setup && !mapped(idx) |=> s_q.pslverr && s_q.pready)
		else $error("unmapped access not refused");

	// Flags move only through their own event or their own read
	a_tb2_read_clr: assert property (rd_done && idx == ltc_pkg::IDX_TB2_CTRL_STATUS
		&& s_q.prdata[ltc_pkg::TB2_FLAG_BIT] && !ovf2 |=> !s_q.tb2_flag)
		else $error("timebase 2 flag not cleared by read");
	a_tb2_flag_hold: assert property (s_q.tb2_flag && !rd_done |=> s_q.tb2_flag)
		else $error("timebase 2 flag lost without read");
	a_tb1_flag_hold: assert property (s_q.tb1_flag && !rd_done |=> s_q.tb1_flag)
		else $error("timebase 1 flag lost without read");
	a_tb1_flag_set: assert property (tb1_event |=> s_q.tb1_flag)
		else $error("timebase 1 flag not set on event");
	a_tb1_short: assert property (wrap1 && !s_q.tb_sel |=> s_q.tb1_flag)
		else $error("short period wrap did not flag");
	a_tb1_no_set: assert property (!tb1_event && !s_q.tb1_flag |=> !s_q.tb1_flag)
		else $error("timebase 1 flag set without event");
	a_tb2_no_set: assert property (!ovf2 && !s_q.tb2_flag |=> !s_q.tb2_flag)
		else $error("timebase 2 flag set without overflow");
	a_cap_no_set: assert property (!cap_event && !s_q.cap_flag |=> !s_q.cap_flag)
		else $error("capture flag set without edge");

	// Software writes cannot touch hardware flags
	a_tb2_flag_wr: assert property (wr_done && idx == ltc_pkg::IDX_TB2_CTRL_STATUS && !ovf2
		|=> s_q.tb2_flag == $past(s_q.tb2_flag))
		else $error("write changed timebase 2 flag");
	a_cap_flag_wr: assert property (wr_done && idx == ltc_pkg::IDX_TB1_CAP_CTRL_STATUS
		&& !cap_event |=> s_q.cap_flag == $past(s_q.cap_flag))
		else $error("write changed capture flag");
	a_tb1_flag_wr: assert property (wr_done && idx == ltc_pkg::IDX_TB1_CAP_CTRL_STATUS
		&& !tb1_event |=> s_q.tb1_flag == $past(s_q.tb1_flag))
		else $error("write changed timebase 1 flag");
	a_ie2_write: assert property (wr_done && idx == ltc_pkg::IDX_TB2_CTRL_STATUS
		|=> s_q.tb2_ie == $past(pwdata[ltc_pkg::TB2_IE_BIT]))
		else $error("timebase 2 enable not written");
	a_sel_write: assert property (wr_done && idx == ltc_pkg::IDX_TB1_CAP_CTRL_STATUS
		|=> s_q.tb_sel == $past(pwdata[ltc_pkg::TB_SEL_BIT]))
		else $error("period select not written");

	// Reload register and counter 2
	a_reload_write: assert property (wr_done && idx == ltc_pkg::IDX_RELOAD
		|=> s_q.reload == $past(pwdata[7:0]))
		else $error("reload value not written");
	a_reload_hold: assert property (!(wr_done && idx == ltc_pkg::IDX_RELOAD)
		|=> $stable(s_q.reload))
		else $error("reload value changed without write");
	a_cnt2_step: assert property (tick && !ovf2 |=> s_q.cnt2 == $past(s_q.cnt2) + 8'h01)
		else $error("counter 2 did not step");
	a_cnt2_idle: assert property (!tick |=> $stable(s_q.cnt2))
		else $error("counter 2 moved between ticks");
	a_count2_read: assert property (setup && !pwrite && idx == ltc_pkg::IDX_COUNT2
		|=> s_q.prdata[7:0] == $past(s_q.cnt2))
		else $error("counter 2 read value wrong");

	// Counter 1 and the long period
	a_cnt1_idle: assert property (!tick |=> $stable(s_q.cnt1))
		else $error("counter 1 moved between ticks");
	a_cnt1_range: assert property (s_q.cnt1 <= ltc_pkg::CNT1_LAST)
		else $error("counter 1 beyond its last value");
	a_cnt1_step: assert property (tick && !wrap1 |=> s_q.cnt1 == $past(s_q.cnt1) + 8'h01)
		else $error("counter 1 did not step");
	a_long_second: assert property (wrap1 && s_q.tb_sel && s_q.tb_half |=> s_q.tb1_flag)
		else $error("long period second wrap not flagged");
	a_half_clear: assert property (wrap1 && !s_q.tb_sel |=> !s_q.tb_half)
		else $error("half period state kept in short mode");
	a_halt_presc: assert property (halt_stop |=> $stable(s_q.presc))
		else $error("prescaler moved during halt");

	// Capture path
	a_pin_track: assert property (1'b1 |=> s_q.pin_prev == $past(capture_input_pin))
		else $error("pin history not tracked");
	a_cap_edge: assert property (capture_input_pin != s_q.pin_prev && !s_q.cap_flag
		|=> s_q.cap_flag)
		else $error("edge with clear flag not captured");
	a_capture_hold: assert property (!cap_event |=> $stable(s_q.capture))
		else $error("capture changed without edge");
	a_capture_read: assert property (setup && !pwrite && idx == ltc_pkg::IDX_CAPTURE
		|=> s_q.prdata[7:0] == $past(s_q.capture))
		else $error("capture read value wrong");
	a_ctrl1_read: assert property (setup && !pwrite && idx == ltc_pkg::IDX_TB1_CAP_CTRL_STATUS
		|=> s_q.prdata[2:0] == 3'h0 && s_q.prdata[ltc_pkg::CAP_FLAG_BIT] == $past(s_q.cap_flag))
		else $error("first status read value wrong");

	// Interrupt status, mask and output
	a_tb2_irq_set: assert property (ovf2 && s_q.tb2_ie |=> s_q.irq_st[ltc_pkg::IRQ_TB2_BIT])
		else $error("timebase 2 request missing");
	a_tb1_irq_set: assert property (tb1_event && s_q.tb1_ie |=> s_q.irq_st[ltc_pkg::IRQ_TB1_BIT])
		else $error("timebase 1 request missing");
	a_cap_irq_set: assert property (cap_event && s_q.cap_ie |=> s_q.irq_st[ltc_pkg::IRQ_CAP_BIT])
		else $error("capture request missing");
	a_irq_level: assert property (s_q.irq == |(s_q.irq_st & s_q.irq_mask))
		else $error("interrupt output not status and mask");
	a_irq_sticky: assert property (!(wr_done && idx == ltc_pkg::IDX_IRQ_STATUS)
		|=> (s_q.irq_st & $past(s_q.irq_st)) == $past(s_q.irq_st))
		else $error("interrupt status lost without write");
	a_irq_clear: assert property (wr_done && idx == ltc_pkg::IDX_IRQ_STATUS && raw_ev == 3'h0
		|=> (s_q.irq_st & $past(pwdata[IRQ_W_L-1:0])) == 3'h0)
		else $error("interrupt status not cleared by write");
	a_mask_write: assert property (wr_done && idx == ltc_pkg::IDX_IRQ_MASK
		|=> s_q.irq_mask == $past(pwdata[IRQ_W_L-1:0]))
		else $error("interrupt mask not written");

	// Bus answer shape
	a_mapped_ok: assert property (setup && mapped(idx) |=> !s_q.pslverr && s_q.pready)
		else $error("mapped access refused");
	a_unmapped_quiet: assert property (wr_done && !mapped(idx)
		|=> $stable(s_q.reload) && $stable(s_q.irq_mask))
		else $error("unmapped write changed state");
	a_pready_pulse: assert property (s_q.pready |=> !s_q.pready)
		else $error("ready held beyond one cycle");
	a_rd_data_hi: assert property (s_q.pready |-> s_q.prdata[31:8] == 24'h000000)
		else $error("read data upper bits nonzero");
	a_wr_data_zero: assert property (setup && pwrite |=> s_q.prdata == 32'h00000000)
		else $error("write returned nonzero data");

	c_capture: cover property (cap_event ##1 rd_done && idx == ltc_pkg::IDX_CAPTURE);
	c_tb2_overflow: cover property (ovf2 && s_q.tb2_ie);
	c_long_event: cover property (tb1_event && s_q.tb_sel);
	c_irq_raise: cover property ($rose(s_q.irq));
	c_halt_tick: cover property (halt_stop && s_q.presc == ltc_pkg::PRESC_LAST);

endmodule

`default_nettype wire

// ---- testbench/ltc_edge_src.sv ----
// Edge source standing on the capture pin of the timer.
// Assumes fire is a one-cycle bench request sampled at pclk.
`timescale 1ns/1ps
`default_nettype none
module ltc_edge_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fire,
	output logic pin
);
	// Each request flips the level, so rise and fall alternate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= 1'b0;
		end else if (fire) begin
			pin <= ~pin;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the timebase and capture timer.
// Assumes the APB slave answers with a one-cycle pready.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic pclk, presetn, psel, penable, pwrite, fire, pin, irq, pready, pslverr, halt;
	logic [7:0] paddr, rel;
	logic [31:0] pwdata, prdata;
	logic [32:0] eq[$], mq[$];
	int miscompares = 0;
	int check_count = 0;
	ltc_timer ltc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.capture_input_pin(pin), .halt_stop(halt), .irq(irq));
	ltc_edge_src ltc_edge_src_inst (.pclk(pclk), .presetn(presetn), .fire(fire), .pin(pin));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic summarize();
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [32:0] g, input logic [32:0] e, input logic [32:0] m);
		check_count++;
		if ((g & m) !== (e & m)) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g & m, e & m);
		end
	endtask
	// One idle cycle after each transfer keeps every signal single-assigned per step
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		int n;
		n = 0;
		if (!w) begin
			eq.push_back(e);
			mq.push_back(m);
		end
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		apb(a, 1'b0, 32'h0, {25'h0, e}, {1'b1, 24'hffffff, m});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(a, 1'b1, {24'h0, d}, 33'h0, 33'h0);
	endtask
	task automatic wirq();
		int n;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (irq !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			miscompares++;
			summarize();
		end
		@(posedge pclk);
	endtask
	task automatic kick();
		fire <= 1'b1;
		@(posedge pclk);
		fire <= 1'b0;
	endtask
	// Watcher side: each completed read takes the oldest expectation
	always @(negedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0)
			cmp({pslverr, prdata}, eq.pop_front(), mq.pop_front());
	end
	initial begin
		{presetn, psel, penable, pwrite, fire, halt, paddr, pwdata} = '0;
		void'($urandom(80));
		// Kept low so a reload period outlasts the reads that follow it
		rel = 8'($urandom) & 8'h7f;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wr(8'h28, 8'hff);
		rd(8'h28, 8'h00, 8'hff);
		rd(8'h20, 8'h00, 8'hff);
		rd(8'h24, 8'h00, 8'hff);
		rd(8'h30, 8'h00, 8'hff);
		rd(8'h38, 8'h00, 8'hff);
		wr(8'h24, rel);
		rd(8'h24, rel, 8'hff);
		apb(8'h40, 1'b0, 32'h0, {1'b1, 32'h0}, {1'b1, 32'h0});
		wr(8'h38, 8'h01);
		wr(8'h2c, 8'h10);
		wirq();
		rd(8'h34, 8'h01, 8'h07);
		rd(8'h2c, 8'h18, 8'hff);
		rd(8'h2c, 8'h10, 8'hff);
		wr(8'h2c, 8'h00);
		wr(8'h34, 8'h07);
		rd(8'h34, 8'h00, 8'h07);
		wr(8'h20, 8'hff);
		rd(8'h20, 8'h02, 8'hfe);
		wr(8'h38, 8'h02);
		wirq();
		halt <= 1'b1;
		repeat (100) @(posedge pclk);
		rd(8'h28, rel, 8'hff);
		rd(8'h34, 8'h02, 8'h07);
		rd(8'h20, 8'h03, 8'hff);
		rd(8'h20, 8'h02, 8'hff);
		halt <= 1'b0;
		wr(8'h20, 8'h00);
		wr(8'h34, 8'h07);
		rd(8'h30, 8'h00, 8'h00);
		wr(8'h38, 8'h04);
		wr(8'h2c, 8'h80);
		kick();
		wirq();
		rd(8'h34, 8'h04, 8'h07);
		rd(8'h2c, 8'hc0, 8'he0);
		rd(8'h30, 8'h00, 8'h00);
		rd(8'h2c, 8'h80, 8'he0);
		wr(8'h34, 8'h07);
		kick();
		wirq();
		rd(8'h2c, 8'hc0, 8'he0);
		wr(8'h34, 8'h07);
		kick();
		repeat (10) @(posedge pclk);
		rd(8'h34, 8'h00, 8'h07);
		summarize();
	end
endmodule
`default_nettype wire
